// ==== hdl/timer16_pkg.sv ====
// Constants and types for the 16-bit timer waveform-mode control block
package timer16_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CTRL_B = 8'h04;
   localparam logic [7:0] OFS_CMP_A = 8'h08;
   localparam logic [7:0] OFS_CMP_B = 8'h0c;
   localparam logic [7:0] OFS_CAPTURE = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
   localparam logic [1:0] MODE_HIGH_RESET = 2'h0;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam int COM_A_LSB = 6;
   localparam int COM_B_LSB = 4;
   localparam int OVF_BIT = 0;
   localparam int DIR_BIT = 1;

   // ------------------------------------------------------------
   // Counter values
   // ------------------------------------------------------------
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] STEP = 16'h0001;

   // ------------------------------------------------------------
   // Compare output modes and toggle-capable waveform modes
   // ------------------------------------------------------------
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
   localparam logic [3:0] MODE_PC_CMPA = 4'hb;
   localparam logic [3:0] MODE_FAST_CAP = 4'he;
   localparam logic [3:0] MODE_FAST_CMPA = 4'hf;

   typedef enum logic [2:0] {SEQ_NORMAL, SEQ_CTC, SEQ_FAST, SEQ_PHASE, SEQ_PFC} seq_e;
   typedef enum logic [1:0] {SRC_FIXED, SRC_CMPA, SRC_CAPTURE} topsrc_e;
   typedef enum logic [1:0] {UPD_NOW, UPD_TOP, UPD_BOTTOM} upd_e;
   typedef enum logic {DIR_UP, DIR_DOWN} dir_e;

   typedef struct packed {
      seq_e seq;
      topsrc_e src;
      logic [15:0] fixedTop;
      upd_e upd;
   } mode_cfg_s;

endpackage

// ==== hdl/timer16_waveform_mode_control.sv ====
// 16-bit timer waveform-mode control with APB register access
// Summary of operation
// R1: Nonzero unit A output mode routes waveform A onto its pin.
// R2: Nonzero unit B output mode routes waveform B onto its pin.
// R3: Software sets the pin direction to output, else the driver stays off.
// R4: Output mode 00 leaves the unit disconnected in every waveform mode.
// R5: Normal and clear-on-match: 01 toggles, 10 clears, 11 sets on match.
// R6: Fast PWM 01: unit A toggles only in modes 14/15; B disconnected.
// R7: Fast PWM 10: clear on match, set at bottom.
// R8: Fast PWM 11: set on match, clear at bottom.
// R9: Fast PWM: match at compare equal top ignored; bottom action still done.
// R10: Dual slope 01: unit A toggles only in modes 9/11; B disconnected.
// R11: Dual slope 10: clear on up-count match, set on down-count match.
// R12: Dual slope 11: set on up-count match, clear on down-count match.
// R13: Four-bit mode joins two low bits and two upper bits.
// R14: Mode 0 normal; 4 and 12 clear on match; immediate update, flag at max.
// R15: Modes 1-3 phase correct, fixed tops; update at top, flag at bottom.
// R16: Modes 5-7, 14, 15 fast PWM; update at bottom, flag at top.
// R17: Modes 8-11 dual slope; top from capture or compare A; flag at bottom.
// R18: Dual slope counts zero to top and back, holding top one tick.
// R19: Software avoids mode 13 and writes zero to reserved bits.
// R20: Control register resets to zero: normal mode, outputs disconnected.
`timescale 1ns/1ps
module timer16_waveform_mode_control (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [timer16_pkg::ADDR_W-1:0] paddr,
   input wire logic [timer16_pkg::DATA_W-1:0] pwdata,
   output logic [timer16_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tickEn,
   output logic waveOutA,
   output logic waveOutB,
   output logic pinOverrideA,
   output logic pinOverrideB,
   output logic overflowFlag
);

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   function automatic timer16_pkg::mode_cfg_s decodeMode(input logic [3:0] m);
      timer16_pkg::mode_cfg_s c;
      c = '{timer16_pkg::SEQ_NORMAL, timer16_pkg::SRC_FIXED, timer16_pkg::MAX,
            timer16_pkg::UPD_NOW};
      unique case (m) // [R13]
         4'h1: c = '{timer16_pkg::SEQ_PHASE, timer16_pkg::SRC_FIXED,
                     timer16_pkg::TOP_8BIT, timer16_pkg::UPD_TOP}; // [R15]
         4'h2: c = '{timer16_pkg::SEQ_PHASE, timer16_pkg::SRC_FIXED,
                     timer16_pkg::TOP_9BIT, timer16_pkg::UPD_TOP};
         4'h3: c = '{timer16_pkg::SEQ_PHASE, timer16_pkg::SRC_FIXED,
                     timer16_pkg::TOP_10BIT, timer16_pkg::UPD_TOP};
         4'h4: c = '{timer16_pkg::SEQ_CTC, timer16_pkg::SRC_CMPA,
                     timer16_pkg::MAX, timer16_pkg::UPD_NOW}; // [R14]
         4'h5: c = '{timer16_pkg::SEQ_FAST, timer16_pkg::SRC_FIXED,
                     timer16_pkg::TOP_8BIT, timer16_pkg::UPD_BOTTOM}; // [R16]
         4'h6: c = '{timer16_pkg::SEQ_FAST, timer16_pkg::SRC_FIXED,
                     timer16_pkg::TOP_9BIT, timer16_pkg::UPD_BOTTOM};
         4'h7: c = '{timer16_pkg::SEQ_FAST, timer16_pkg::SRC_FIXED,
                     timer16_pkg::TOP_10BIT, timer16_pkg::UPD_BOTTOM};
         4'h8: c = '{timer16_pkg::SEQ_PFC, timer16_pkg::SRC_CAPTURE,
                     timer16_pkg::MAX, timer16_pkg::UPD_BOTTOM}; // [R17]
         4'h9: c = '{timer16_pkg::SEQ_PFC, timer16_pkg::SRC_CMPA,
                     timer16_pkg::MAX, timer16_pkg::UPD_BOTTOM};
         4'ha: c = '{timer16_pkg::SEQ_PHASE, timer16_pkg::SRC_CAPTURE,
                     timer16_pkg::MAX, timer16_pkg::UPD_TOP};
         4'hb: c = '{timer16_pkg::SEQ_PHASE, timer16_pkg::SRC_CMPA,
                     timer16_pkg::MAX, timer16_pkg::UPD_TOP};
         4'hc: c = '{timer16_pkg::SEQ_CTC, timer16_pkg::SRC_CAPTURE,
                     timer16_pkg::MAX, timer16_pkg::UPD_NOW}; // [R14]
         4'he: c = '{timer16_pkg::SEQ_FAST, timer16_pkg::SRC_CAPTURE,
                     timer16_pkg::MAX, timer16_pkg::UPD_BOTTOM};
         4'hf: c = '{timer16_pkg::SEQ_FAST, timer16_pkg::SRC_CMPA,
                     timer16_pkg::MAX, timer16_pkg::UPD_BOTTOM};
         // Reserved mode 13 falls back to plain counting
         default: c.seq = timer16_pkg::SEQ_NORMAL;
      endcase
      return c;
   endfunction

   logic [7:0] ctrlA;
   logic [1:0] modeHigh;
   logic [15:0] bufVal [2];
   logic [15:0] cmpVal [2];
   logic [15:0] capture;
   logic [15:0] count;
   logic [15:0] next_count;
   timer16_pkg::dir_e dir;
   timer16_pkg::dir_e next_dir;
   logic wave [2];
   logic over [2];
   logic match [2];
   logic [1:0] com [2];
   logic [3:0] mode;
   timer16_pkg::mode_cfg_s cfg;
   logic [15:0] top;
   logic atTop;
   logic atBottom;
   logic dual;
   logic bottomTick;
   logic topTick;
   logic ovfEvent;
   logic wrEn;
   logic [31:0] rdData;
   logic addrHit;

   assign mode = {modeHigh, ctrlA[1:0]}; // [R13]
   assign cfg = decodeMode(mode);
   assign com[0] = ctrlA[timer16_pkg::COM_A_LSB +: 2];
   assign com[1] = ctrlA[timer16_pkg::COM_B_LSB +: 2];
   assign dual = cfg.seq inside {timer16_pkg::SEQ_PHASE, timer16_pkg::SEQ_PFC};
   assign atTop = count == top;
   assign atBottom = count == timer16_pkg::BOTTOM;
   // Fast PWM reaches bottom on the wrap from top
   assign bottomTick = tickEn && (cfg.seq == timer16_pkg::SEQ_FAST ? atTop
                       : (atBottom && dir == timer16_pkg::DIR_DOWN));
   assign topTick = tickEn && atTop && dir == timer16_pkg::DIR_UP;

   always_comb begin
      unique case (cfg.src)
         timer16_pkg::SRC_CMPA: top = cmpVal[0];
         timer16_pkg::SRC_CAPTURE: top = capture;
         default: top = cfg.fixedTop;
      endcase
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign wrEn = psel && penable && pready && pwrite;

   always_comb begin
      rdData = '0;
      addrHit = 1'b1;
      case (paddr)
         timer16_pkg::OFS_CTRL_A: rdData[7:0] = ctrlA & timer16_pkg::CTRL_A_WMASK; // [R19]
         timer16_pkg::OFS_CTRL_B: rdData[1:0] = modeHigh;
         timer16_pkg::OFS_CMP_A: rdData[15:0] = bufVal[0];
         timer16_pkg::OFS_CMP_B: rdData[15:0] = bufVal[1];
         timer16_pkg::OFS_CAPTURE: rdData[15:0] = capture;
         timer16_pkg::OFS_COUNT: rdData[15:0] = count;
         timer16_pkg::OFS_STATUS: begin
            rdData[timer16_pkg::OVF_BIT] = overflowFlag;
            rdData[timer16_pkg::DIR_BIT] = dir == timer16_pkg::DIR_DOWN;
         end
         default: addrHit = 1'b0;
      endcase
   end

   // Zero wait states: answer in the first access cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addrHit;
         if (psel && !penable) begin
            prdata <= rdData;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrlA <= timer16_pkg::CTRL_A_RESET; // [R20]
         modeHigh <= timer16_pkg::MODE_HIGH_RESET;
         capture <= timer16_pkg::VALUE_RESET;
      end else if (wrEn) begin
         if (paddr == timer16_pkg::OFS_CTRL_A) begin
            ctrlA <= pwdata[7:0] & timer16_pkg::CTRL_A_WMASK;
         end
         if (paddr == timer16_pkg::OFS_CTRL_B) begin
            modeHigh <= pwdata[1:0];
         end
         if (paddr == timer16_pkg::OFS_CAPTURE) begin
            capture <= pwdata[15:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Counter sequence
   // ------------------------------------------------------------
   always_comb begin
      next_count = count;
      next_dir = dir;
      if (tickEn) begin
         unique case (cfg.seq)
            timer16_pkg::SEQ_NORMAL: next_count = count + timer16_pkg::STEP; // [R14]
            timer16_pkg::SEQ_CTC, timer16_pkg::SEQ_FAST: begin
               next_count = atTop ? timer16_pkg::BOTTOM : count + timer16_pkg::STEP;
            end
            timer16_pkg::SEQ_PHASE, timer16_pkg::SEQ_PFC: begin
               // Top and bottom each last exactly one tick
               if (dir == timer16_pkg::DIR_UP) begin // [R18]
                  next_dir = atTop ? timer16_pkg::DIR_DOWN : timer16_pkg::DIR_UP;
                  next_count = atTop ? count - timer16_pkg::STEP : count + timer16_pkg::STEP;
               end else begin
                  next_dir = atBottom ? timer16_pkg::DIR_UP : timer16_pkg::DIR_DOWN;
                  next_count = atBottom ? count + timer16_pkg::STEP : count - timer16_pkg::STEP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count <= timer16_pkg::VALUE_RESET;
         dir <= timer16_pkg::DIR_UP;
      end else begin
         count <= next_count;
         // Leaving a dual-slope mode must not strand a down count
         dir <= dual ? next_dir : timer16_pkg::DIR_UP;
      end
   end

   // ------------------------------------------------------------
   // Overflow flag, set wins over write-one-to-clear
   // ------------------------------------------------------------
   always_comb begin
      unique case (cfg.seq)
         timer16_pkg::SEQ_FAST: ovfEvent = tickEn && atTop; // [R16]
         timer16_pkg::SEQ_PHASE, timer16_pkg::SEQ_PFC: ovfEvent = bottomTick; // [R15] [R17]
         default: ovfEvent = tickEn && count == timer16_pkg::MAX; // [R14]
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         overflowFlag <= 1'b0;
      end else if (ovfEvent) begin
         overflowFlag <= 1'b1;
      end else if (wrEn && paddr == timer16_pkg::OFS_STATUS && pwdata[timer16_pkg::OVF_BIT]) begin
         overflowFlag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Compare units
   // ------------------------------------------------------------
   for (genvar ch = 0; ch < 2; ch++) begin : g_unit
      localparam logic [7:0] OFS = ch == 0 ? timer16_pkg::OFS_CMP_A : timer16_pkg::OFS_CMP_B;
      logic toggleFast;
      logic toggleDual;
      logic next_wave;
      logic next_over;
      logic load;

      assign match[ch] = tickEn && count == cmpVal[ch];
      assign toggleFast = ch == 0 && mode inside {timer16_pkg::MODE_FAST_CAP,
                          timer16_pkg::MODE_FAST_CMPA};
      assign toggleDual = ch == 0 && mode inside {timer16_pkg::MODE_PFC_CMPA,
                          timer16_pkg::MODE_PC_CMPA};

      always_comb begin
         unique case (cfg.upd)
            timer16_pkg::UPD_TOP: load = topTick; // [R15]
            timer16_pkg::UPD_BOTTOM: load = bottomTick; // [R16] [R17]
            default: load = 1'b1; // [R14]
         endcase
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            bufVal[ch] <= timer16_pkg::VALUE_RESET;
            cmpVal[ch] <= timer16_pkg::VALUE_RESET;
         end else begin
            if (wrEn && paddr == OFS) begin
               bufVal[ch] <= pwdata[15:0];
            end
            if (load) begin
               cmpVal[ch] <= bufVal[ch];
            end
         end
      end

      always_comb begin
         next_wave = wave[ch];
         next_over = com[ch] != timer16_pkg::COM_OFF; // [R1] [R2] [R4]
         unique case (cfg.seq)
            timer16_pkg::SEQ_FAST: begin
               if (com[ch] == timer16_pkg::COM_TOGGLE) begin
                  next_over = toggleFast; // [R6]
                  if (match[ch] && toggleFast) begin
                     next_wave = !wave[ch];
                  end
               end else if (com[ch][1]) begin
                  if (match[ch] && cmpVal[ch] != top) begin // [R9]
                     next_wave = com[ch] == timer16_pkg::COM_SET; // [R7] [R8]
                  end else if (bottomTick) begin
                     next_wave = com[ch] == timer16_pkg::COM_CLEAR; // [R7] [R8]
                  end
               end
            end
            timer16_pkg::SEQ_PHASE, timer16_pkg::SEQ_PFC: begin
               if (com[ch] == timer16_pkg::COM_TOGGLE) begin
                  next_over = toggleDual; // [R10]
                  if (match[ch] && toggleDual) begin
                     next_wave = !wave[ch];
                  end
               end else if (com[ch][1] && match[ch]) begin
                  // Up-count match follows the mode, down-count the opposite
                  next_wave = (dir == timer16_pkg::DIR_UP) ==
                              (com[ch] == timer16_pkg::COM_SET); // [R11] [R12]
               end
            end
            default: begin
               if (match[ch]) begin
                  unique case (com[ch]) // [R5]
                     timer16_pkg::COM_TOGGLE: next_wave = !wave[ch];
                     timer16_pkg::COM_CLEAR: next_wave = 1'b0;
                     timer16_pkg::COM_SET: next_wave = 1'b1;
                     default: next_wave = wave[ch];
                  endcase
               end
            end
         endcase
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            wave[ch] <= 1'b0;
            over[ch] <= 1'b0; // [R20]
         end else begin
            wave[ch] <= next_wave;
            over[ch] <= next_over;
         end
      end
   end

   // Pin direction stays with the port logic outside
   assign waveOutA = wave[0];
   assign waveOutB = wave[1];
   assign pinOverrideA = over[0]; // [R3]
   assign pinOverrideB = over[1];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_off_disc;
      com[0] == timer16_pkg::COM_OFF |=> !pinOverrideA;
   endproperty
   a_off_disc: assert property (p_off_disc) else $error("A not disconnected"); // [R4]

   property p_conn_a;
      com[0] != timer16_pkg::COM_OFF && cfg.seq inside {timer16_pkg::SEQ_NORMAL,
         timer16_pkg::SEQ_CTC} |=> pinOverrideA;
   endproperty
   a_conn_a: assert property (p_conn_a) else $error("A not routed"); // [R1]

   property p_conn_b;
      com[1] == timer16_pkg::COM_CLEAR |=> pinOverrideB;
   endproperty
   a_conn_b: assert property (p_conn_b) else $error("B not routed"); // [R2]

   property p_set_match;
      cfg.seq inside {timer16_pkg::SEQ_NORMAL, timer16_pkg::SEQ_CTC}
         && com[0] == timer16_pkg::COM_SET && match[0] |=> waveOutA;
   endproperty
   a_set_match: assert property (p_set_match) else $error("A not set on match"); // [R5]

   property p_fast_b_tog;
      cfg.seq == timer16_pkg::SEQ_FAST && com[1] == timer16_pkg::COM_TOGGLE
         |=> !pinOverrideB && $stable(waveOutB);
   endproperty
   a_fast_b_tog: assert property (p_fast_b_tog) else $error("B not disconnected"); // [R6]

   property p_fast_bottom;
      cfg.seq == timer16_pkg::SEQ_FAST && com[0] == timer16_pkg::COM_CLEAR
         && tickEn && atTop |=> waveOutA;
   endproperty
   a_fast_bottom: assert property (p_fast_bottom) else $error("A not set at bottom"); // [R7]

   property p_fast_inv;
      cfg.seq == timer16_pkg::SEQ_FAST && com[0] == timer16_pkg::COM_SET
         && tickEn && atTop |=> !waveOutA;
   endproperty
   a_fast_inv: assert property (p_fast_inv) else $error("A not cleared at bottom"); // [R8]

   property p_dual_up;
      dual && com[0] == timer16_pkg::COM_CLEAR && match[0] && dir == timer16_pkg::DIR_UP
         |=> !waveOutA;
   endproperty
   a_dual_up: assert property (p_dual_up) else $error("A not cleared up-count"); // [R11]

   localparam logic [15:0] STEP_V = timer16_pkg::STEP;
   property p_top_hold;
      dual && topTick |=> dir == timer16_pkg::DIR_DOWN && count == $past(count) - STEP_V;
   endproperty
   a_top_hold: assert property (p_top_hold) else $error("Top not left after one tick"); // [R18]

   property p_ovf_bottom;
      dual && bottomTick |=> overflowFlag;
   endproperty
   a_ovf_bottom: assert property (p_ovf_bottom) else $error("Flag not set at bottom"); // [R15]

   property p_fast_load;
      cfg.seq == timer16_pkg::SEQ_FAST && tickEn && atTop |=> cmpVal[0] == $past(bufVal[0]);
   endproperty
   a_fast_load: assert property (p_fast_load) else $error("Compare A not loaded"); // [R16]

endmodule

// ==== verification/wave_pin_model.sv ====
// External pin driven by one compare waveform output
`timescale 1ns/1ps
module wave_pin_model (
   input wire logic waveOut,
   input wire logic pinOverride,
   input wire logic dirOut,
   input wire logic portLevel,
   output logic pinLevel
);
   // Driver off unless direction is output; the pin then rests at its pull-up
   assign pinLevel = dirOut ? (pinOverride ? waveOut : portLevel) : 1'b1;
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench with a reference model of the waveform-mode block
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic tickEn = 1'b0, dirOut = 1'b0, portLevel = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdData;
   logic pready, pslverr, errSeen, waveOutA, waveOutB, pinOverrideA, pinOverrideB;
   logic overflowFlag, pinA;
   int num_errors = 0, samples_checked = 0;
   int cnt, dir, ovf, wa, wb, oa, ob, ba, bb, icr, ca, cb, row;
   // Mode, output modes A and B, compare A, compare B, capture, steps
   int tbl[16][6] = '{'{0, 7, 16'h1234, 16'h100, 0, 65540}, '{4, 9, 16'h40, 16'h20, 0, 400},
      '{12, 14, 16'h10, 16'h28, 16'h30, 400}, '{5, 11, 16'h40, 16'h80, 0, 700},
      '{14, 5, 16'h20, 16'h30, 16'h50, 400}, '{15, 14, 16'h60, 16'h60, 0, 400},
      '{6, 6, 16'h100, 16'h1ff, 0, 1200}, '{7, 11, 16'h200, 16'h300, 0, 2200},
      '{1, 11, 16'h40, 16'h80, 0, 1100}, '{2, 14, 16'h100, 16'h40, 0, 2100},
      '{3, 10, 16'h200, 16'h100, 0, 4200}, '{8, 13, 16'h20, 16'h30, 16'h50, 400},
      '{9, 6, 16'h50, 16'h20, 0, 400}, '{10, 11, 16'h20, 16'h30, 16'h60, 500},
      '{11, 7, 16'h48, 16'h20, 0, 400}, '{13, 8, 16'h30, 16'h40, 0, 300}};

   timer16_waveform_mode_control uut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tickEn, .waveOutA, .waveOutB, .pinOverrideA,
      .pinOverrideB, .overflowFlag);
   wave_pin_model pinModelA (.waveOut(waveOutA), .pinOverride(pinOverrideA), .dirOut,
      .portLevel, .pinLevel(pinA));

   always #10 clk_sys = ~clk_sys;

   // --------------------------------
   // Reference model
   // --------------------------------
   function automatic int curMode();
      int m = (cb & 3) * 4 + (ca & 3);
      return m == 13 ? 0 : m;
   endfunction
   function automatic int topOf(int m);
      case (m)
         1, 5: return 255;
         2, 6: return 511;
         3, 7: return 1023;
         4, 9, 11, 15: return oa;
         8, 10, 12, 14: return icr;
         default: return 65535;
      endcase
   endfunction
   function automatic bit isFast(int m);
      return m inside {5, 6, 7, 14, 15};
   endfunction
   function automatic bit isDual(int m);
      return m inside {1, 2, 3, 8, 9, 10, 11};
   endfunction
   // Toggle in PWM modes is legal on unit A only, and only in four modes
   function automatic bit conn(int com, int m, bit unitA);
      return com != 0 && !(com == 1 && (isFast(m) || isDual(m))
         && !(unitA && m inside {9, 11, 14, 15}));
   endfunction
   task automatic load();
      oa = ba;
      ob = bb;
   endtask
   task automatic act(inout int w, input int com, input bit on, hit, bot, dn);
      if (on && hit)
         w = com == 1 ? !w : (dn ? com == 2 : com == 3);
      if (on && bot && com >= 2)
         w = com == 2;
   endtask
   task automatic modelTick();
      int m = curMode();
      int t = topOf(m);
      bit dn = isDual(m) && dir == 1;
      bit bot = isFast(m) && cnt == t;
      act(wa, ca >> 6 & 3, conn(ca >> 6 & 3, m, 1),
         cnt == oa && !(isFast(m) && oa == t && ca[7]), bot, dn);
      act(wb, ca >> 4 & 3, conn(ca >> 4 & 3, m, 0),
         cnt == ob && !(isFast(m) && ob == t && ca[5]), bot, dn);
      if (isFast(m)) begin
         ovf = bot ? 1 : ovf;
         if (bot)
            load();
         cnt = bot ? 0 : cnt + 1;
      end else if (isDual(m)) begin
         if (!dn && cnt == t) begin
            dir = 1;
            if (m inside {1, 2, 3, 10, 11})
               load();
         end else if (dn && cnt == 0) begin
            dir = 0;
            ovf = 1;
            if (m inside {8, 9})
               load();
         end
         cnt += dir ? -1 : 1;
      end else begin
         ovf = cnt == 65535 ? 1 : ovf;
         cnt = (m == 4 || m == 12) && cnt == t ? 0 : (cnt + 1) & 65535;
         load();
      end
   endtask

   // --------------------------------
   // Drivers and checks
   // --------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic checkOut();
      bit oA = conn(ca >> 6 & 3, curMode(), 1);
      bit oB = conn(ca >> 4 & 3, curMode(), 0);
      chk(pinOverrideA, oA);
      chk(pinOverrideB, oB);
      chk(overflowFlag, ovf);
      if (oA)
         chk(waveOutA, wa);
      if (oB)
         chk(waveOutB, wb);
      chk(pinA, dirOut ? (oA ? wa : portLevel) : 1);
   endtask
   task automatic step(input bit en);
      @(posedge clk_sys);
      if (tickEn && rst_n)
         modelTick();
      tickEn <= en;
      dirOut <= 1'($urandom);
      portLevel <= 1'($urandom);
      @(negedge clk_sys);
      checkOut();
   endtask
   task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      num_errors += n >= 20;
      rdData = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wrt(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      case (a)
         timer16_pkg::OFS_CTRL_A: ca = d & 32'hf3;
         timer16_pkg::OFS_CTRL_B: cb = d & 32'h3;
         timer16_pkg::OFS_CMP_A: ba = d & 32'hffff;
         timer16_pkg::OFS_CMP_B: bb = d & 32'hffff;
         timer16_pkg::OFS_CAPTURE: icr = d & 32'hffff;
         timer16_pkg::OFS_STATUS: ovf = d[0] ? 0 : ovf;
         default: ;
      endcase
      if (!isFast(curMode()) && !isDual(curMode()))
         load();
   endtask
   task automatic doReset(input int cyc);
      rst_n <= 1'b0;
      repeat (cyc) @(posedge clk_sys);
      rst_n <= 1'b1;
      {cnt, dir, ovf, wa, wb, oa, ob, ba, bb, icr, ca, cb} = '0;
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      void'($urandom(78383));
      doReset(10);
      apb(1'b0, timer16_pkg::OFS_CTRL_A, 32'h0);
      chk(rdData, 32'h0);
      wrt(timer16_pkg::OFS_CTRL_A, 32'hff);
      apb(1'b0, timer16_pkg::OFS_CTRL_A, 32'h0);
      chk(rdData, 32'hf3);
      apb(1'b0, 8'h40, 32'h0);
      chk(errSeen, 1'b1);
      for (row = 0; row < 16; row++) begin
         step(1'b0);
         doReset(2);
         wrt(timer16_pkg::OFS_CMP_A, tbl[row][2]);
         wrt(timer16_pkg::OFS_CMP_B, tbl[row][3]);
         wrt(timer16_pkg::OFS_CAPTURE, tbl[row][4]);
         wrt(timer16_pkg::OFS_CTRL_B, tbl[row][0] >> 2);
         wrt(timer16_pkg::OFS_CTRL_A, tbl[row][1] << 4 | tbl[row][0] & 3);
         for (int i = 0; i < tbl[row][5]; i++) begin
            step(tbl[row][0] == 0 || $urandom % 4 != 0);
            if (i == tbl[row][5] / 2) begin
               step(1'b0);
               apb(1'b0, timer16_pkg::OFS_COUNT, 32'h0);
               chk(rdData, cnt);
               apb(1'b0, timer16_pkg::OFS_STATUS, 32'h0);
               chk(rdData, dir * 2 + ovf);
               wrt(timer16_pkg::OFS_STATUS, 32'h1);
               // New compare B mid-period shows when the active copy takes it
               wrt(timer16_pkg::OFS_CMP_B, 8 + $urandom % 32);
            end
         end
      end
      wrap_up();
   end

   initial begin
      #(20 * 95000);
      num_errors++;
      wrap_up();
   end
endmodule
